// ---- rtl/ipw_pkg.sv ----
/*
  Shared constants for the indexed-port watchdog: port addresses, keys,
  register indices, field positions, reset values and tick timing.
  Assumes a single 25 MHz device clock.
*/
package ipw_pkg;
  // Host I/O locations of the index and data ports.
  localparam logic [15:0] IDX_PORT_ADDR = 16'h002e;
  localparam logic [15:0] DAT_PORT_ADDR = 16'h002f;
  // Keys written to the index port.
  localparam logic [7:0] UNLOCK_KEY = 8'h87;
  localparam logic [7:0] LOCK_KEY = 8'haa;
  // Register indices.
  localparam logic [7:0] BANK_SELECT_IDX = 8'h07;
  localparam logic [7:0] FUNCTION_ACTIVATE_IDX = 8'h30;
  localparam logic [7:0] COUNT_UNIT_SELECT_IDX = 8'hf5;
  localparam logic [7:0] TIMEOUT_COUNT_IDX = 8'hf6;
  localparam logic [7:0] RESTART_STATUS_IDX = 8'hf7;
  // Values that select the watchdog bank and enable the function.
  localparam logic [7:0] WDT_BANK_VALUE = 8'h08;
  localparam logic [7:0] ENABLE_VALUE = 8'h01;
  // Field positions.
  localparam int UNIT_MINUTES_BIT = 3;
  localparam int MOUSE_RESTART_BIT = 7;
  localparam int KBD_RESTART_BIT = 6;
  localparam int FORCE_TIMEOUT_BIT = 5;
  localparam int TIMEOUT_STATUS_BIT = 4;
  // Reset values.
  localparam logic [7:0] UNIT_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] BANK_RESET = 8'h00;
  // Tick timing.
  localparam int CLK_HZ = 25000000;
  localparam int TICK_PERIOD_S = 1;
  localparam int SEC_CYCLES = CLK_HZ * TICK_PERIOD_S;
  localparam int SEC_PER_MIN = 60;
endpackage

// ---- rtl/ipw_prescaler.sv ----
/*
  Free-running divider that emits a one-cycle pulse every DIV input pulses.
  Assumes the input pulse is synchronous to ref_clk; clear restarts the phase.
*/
module ipw_prescaler #(
  parameter int DIV = 60
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic inPulse,
  output logic outPulse
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;

  // Count input pulses; wrap and fire on the last one.
  always_comb begin
    cnt_d = cnt_q;
    outPulse = 1'b0;
    if (clear) begin
      cnt_d = '0;
    end else if (inPulse) begin
      if (cnt_q == LAST) begin
        cnt_d = '0;
        outPulse = 1'b1;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule

// ---- rtl/ipw_config_port.sv ----
/*
  Index/data port front end: decodes the two host I/O locations, tracks the
  unlock key sequence and holds the selected index.
  Assumes one-cycle host write/read strobes synchronous to ref_clk.
*/
module ipw_config_port (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ioWr,
  input wire logic ioRd,
  input wire logic [15:0] ioAddr,
  input wire logic [7:0] ioWrData,
  output logic unlocked,
  output logic [7:0] regIndex,
  output logic dataWr,
  output logic dataRd
);
  logic [1:0] keyCnt_q;
  logic [1:0] keyCnt_d;
  logic [7:0] idx_q;
  logic [7:0] idx_d;
  logic idxWr;

  assign idxWr = ioWr && (ioAddr == ipw_pkg::IDX_PORT_ADDR);
  // Data-port strobes pass only while unlocked; locked accesses vanish here.
  assign dataWr = ioWr && (ioAddr == ipw_pkg::DAT_PORT_ADDR) && unlocked;
  assign dataRd = ioRd && (ioAddr == ipw_pkg::DAT_PORT_ADDR) && unlocked;
  assign unlocked = (keyCnt_q == 2'd2);
  assign regIndex = idx_q;

  // Key tracker: two successive unlock keys open access, the lock key closes it.
  always_comb begin
    keyCnt_d = keyCnt_q;
    idx_d = idx_q;
    if (idxWr) begin
      if (unlocked) begin
        if (ioWrData == ipw_pkg::LOCK_KEY) begin
          keyCnt_d = 2'd0;
        end else begin
          idx_d = ioWrData;
        end
      end else if (ioWrData == ipw_pkg::UNLOCK_KEY) begin
        keyCnt_d = keyCnt_q + 2'd1;
      end else begin
        keyCnt_d = 2'd0; // A stray byte breaks the key sequence.
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      keyCnt_q <= 2'd0;
      idx_q <= 8'h00;
    end else begin
      keyCnt_q <= keyCnt_d;
      idx_q <= idx_d;
    end
  end
endmodule

// ---- rtl/ipw_watchdog.sv ----
/*
  Indexed-port watchdog timer top: register bank behind an index/data port
  pair, seconds or minutes countdown, restart sources, forced timeout and
  timeout outputs as interrupt or system reset.
  Assumes host strobes, activity pulses and the select jumper are synchronous
  to ref_clk; the jumper is static.
*/
// How it works
// - Index port and data port are decoded at two adjacent host I/O locations.
// - Unlock key written twice in a row opens configuration; before that, ignored.
// - Bank-select value at the bank-select index targets the watchdog register set.
// - Enable value at the activation index turns the watchdog on; reset leaves it off.
// - Unit register bit 3 chooses seconds (0, reset) or minutes (1).
// - Count value zero stops the timer; count resets to zero.
// - Count 1 to 255 sets the timeout length in the chosen unit.
// - Elapsed count without restart raises timeout as interrupt or reset.
// - Each count register write reloads the counter and restarts counting.
// - Control bit 7 lets mouse activity restart the count; resets to 0.
// - Control bit 6 lets keyboard activity restart the count; resets to 0.
// - Writing control bit 5 forces an immediate timeout; bit self-clears.
// - Control bit 4 reads 1 once timeout has been reached.
// - Lock key at the index port closes configuration until unlocked again.
// - A static jumper input decides whether timeout drives system reset.
module ipw_watchdog #(
  parameter int SEC_DIV = ipw_pkg::SEC_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ioWr,
  input wire logic ioRd,
  input wire logic [15:0] ioAddr,
  input wire logic [7:0] ioWrData,
  output logic [7:0] ioRdData,
  input wire logic mouseActivity,
  input wire logic kbdActivity,
  input wire logic timeoutResetSelectJumper,
  output logic wdtIrq,
  output logic sysReset
);
  logic unlocked;
  logic [7:0] regIndex;
  logic dataWr;
  logic dataRd;
  logic secTick;
  logic minTick;
  logic unitTick;
  logic restartCnt;

  logic [7:0] bank_q, bank_d;
  logic enable_q, enable_d;
  logic minutes_q, minutes_d;
  logic [7:0] countReg_q, countReg_d;
  logic mouseEn_q, mouseEn_d;
  logic kbdEn_q, kbdEn_d;
  logic forceTo_q, forceTo_d;
  logic timedOut_q, timedOut_d;
  logic [7:0] counter_q, counter_d;
  logic [7:0] rdData_q, rdData_d;
  logic timeoutEvt;
  logic bankSel;

  // Front end: address decode, key sequence and index latch.
  ipw_config_port u_port (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ioWr(ioWr),
    .ioRd(ioRd),
    .ioAddr(ioAddr),
    .ioWrData(ioWrData),
    .unlocked(unlocked),
    .regIndex(regIndex),
    .dataWr(dataWr),
    .dataRd(dataRd)
  );

  // Second tick from the device clock; phase restarts with the count.
  ipw_prescaler #(
    .DIV(SEC_DIV)
  ) u_sec (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clear(restartCnt),
    .inPulse(1'b1),
    .outPulse(secTick)
  );

  // Minute tick from sixty second ticks.
  ipw_prescaler #(
    .DIV(ipw_pkg::SEC_PER_MIN)
  ) u_min (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clear(restartCnt),
    .inPulse(secTick),
    .outPulse(minTick)
  );

  function automatic logic isWdtReg(input logic [7:0] idx, input logic [7:0] bank);
    isWdtReg = (bank == ipw_pkg::WDT_BANK_VALUE) &&
               (idx == ipw_pkg::FUNCTION_ACTIVATE_IDX || idx == ipw_pkg::COUNT_UNIT_SELECT_IDX ||
                idx == ipw_pkg::TIMEOUT_COUNT_IDX || idx == ipw_pkg::RESTART_STATUS_IDX);
  endfunction

  assign bankSel = isWdtReg(regIndex, bank_q);
  assign unitTick = minutes_q ? minTick : secTick;

  // Restart on count write or enabled activity, both keep phase aligned.
  assign restartCnt = (dataWr && bankSel && regIndex == ipw_pkg::TIMEOUT_COUNT_IDX) ||
                      (mouseEn_q && mouseActivity) ||
                      (kbdEn_q && kbdActivity);

  // Expiry fires on the tick that takes the counter from one to zero.
  assign timeoutEvt = forceTo_q ||
                      (enable_q && !restartCnt && unitTick && counter_q == 8'h01);

  // Register bank: writes land only when unlocked; all but the bank-select register also need the bank selected.
  always_comb begin
    bank_d = bank_q;
    enable_d = enable_q;
    minutes_d = minutes_q;
    countReg_d = countReg_q;
    mouseEn_d = mouseEn_q;
    kbdEn_d = kbdEn_q;
    forceTo_d = 1'b0; // Self-clearing one cycle after the write.
    timedOut_d = timedOut_q;
    if (dataWr) begin
      if (regIndex == ipw_pkg::BANK_SELECT_IDX) begin
        bank_d = ioWrData;
      end else if (bankSel) begin
        unique case (regIndex)
          ipw_pkg::FUNCTION_ACTIVATE_IDX: enable_d = (ioWrData == ipw_pkg::ENABLE_VALUE);
          ipw_pkg::COUNT_UNIT_SELECT_IDX: minutes_d = ioWrData[ipw_pkg::UNIT_MINUTES_BIT];
          ipw_pkg::TIMEOUT_COUNT_IDX: countReg_d = ioWrData;
          ipw_pkg::RESTART_STATUS_IDX: begin
            mouseEn_d = ioWrData[ipw_pkg::MOUSE_RESTART_BIT];
            kbdEn_d = ioWrData[ipw_pkg::KBD_RESTART_BIT];
            forceTo_d = ioWrData[ipw_pkg::FORCE_TIMEOUT_BIT];
            // Writing 1 to the status bit clears it; a same-cycle timeout still wins below.
            if (ioWrData[ipw_pkg::TIMEOUT_STATUS_BIT]) begin
              timedOut_d = 1'b0;
            end
          end
          default: ;
        endcase
      end
    end
    if (timeoutEvt) begin
      timedOut_d = 1'b1;
    end
  end

  // Countdown: a reload restarts from the written value, zero holds stopped.
  always_comb begin
    counter_d = counter_q;
    if (dataWr && bankSel && regIndex == ipw_pkg::TIMEOUT_COUNT_IDX) begin
      counter_d = ioWrData;
    end else if (restartCnt) begin
      counter_d = countReg_q;
    end else if (enable_q && unitTick && counter_q != 8'h00) begin
      counter_d = counter_q - 8'h01;
    end
  end

  // Read data is registered so the host sees a stable byte after the strobe.
  always_comb begin
    rdData_d = rdData_q;
    if (dataRd) begin
      rdData_d = 8'h00;
      if (regIndex == ipw_pkg::BANK_SELECT_IDX) begin
        rdData_d = bank_q;
      end else if (bankSel) begin
        unique case (regIndex)
          ipw_pkg::FUNCTION_ACTIVATE_IDX: rdData_d = {7'h00, enable_q};
          ipw_pkg::COUNT_UNIT_SELECT_IDX: rdData_d[ipw_pkg::UNIT_MINUTES_BIT] = minutes_q;
          ipw_pkg::TIMEOUT_COUNT_IDX: rdData_d = countReg_q;
          ipw_pkg::RESTART_STATUS_IDX: begin
            rdData_d[ipw_pkg::MOUSE_RESTART_BIT] = mouseEn_q;
            rdData_d[ipw_pkg::KBD_RESTART_BIT] = kbdEn_q;
            rdData_d[ipw_pkg::FORCE_TIMEOUT_BIT] = forceTo_q;
            rdData_d[ipw_pkg::TIMEOUT_STATUS_BIT] = timedOut_q;
          end
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bank_q <= ipw_pkg::BANK_RESET;
      enable_q <= 1'b0;
      minutes_q <= ipw_pkg::UNIT_RESET[ipw_pkg::UNIT_MINUTES_BIT];
      countReg_q <= ipw_pkg::COUNT_RESET;
      mouseEn_q <= ipw_pkg::CTRL_RESET[ipw_pkg::MOUSE_RESTART_BIT];
      kbdEn_q <= ipw_pkg::CTRL_RESET[ipw_pkg::KBD_RESTART_BIT];
      forceTo_q <= ipw_pkg::CTRL_RESET[ipw_pkg::FORCE_TIMEOUT_BIT];
      timedOut_q <= 1'b0;
      counter_q <= ipw_pkg::COUNT_RESET;
      rdData_q <= 8'h00;
    end else begin
      bank_q <= bank_d;
      enable_q <= enable_d;
      minutes_q <= minutes_d;
      countReg_q <= countReg_d;
      mouseEn_q <= mouseEn_d;
      kbdEn_q <= kbdEn_d;
      forceTo_q <= forceTo_d;
      timedOut_q <= timedOut_d;
      counter_q <= counter_d;
      rdData_q <= rdData_d;
    end
  end

  // Timeout routing: the jumper steers it to system reset, else to interrupt.
  // Both are levels that follow the sticky status, so a reset sees a held request.
  assign sysReset = timedOut_q && timeoutResetSelectJumper;
  assign wdtIrq = timedOut_q && !timeoutResetSelectJumper;
  assign ioRdData = rdData_q;
endmodule

// ---- verification/ipw_host_model.sv ----
/*
  Host processor model: byte accesses on the index and data ports.
  Assumes the design samples strobes on the rising edge of ref_clk.
*/
module ipw_host_model (
  input wire logic ref_clk,
  output logic ioWr,
  output logic ioRd,
  output logic [15:0] ioAddr,
  output logic [7:0] ioWrData,
  input wire logic [7:0] ioRdData
);
  // Idle bus at time zero.
  initial begin
    ioWr = 1'b0;
    ioRd = 1'b0;
    ioAddr = 16'h0000;
    ioWrData = 8'h00;
  end
  // Released lines show the inverse, so a stale value never passes for a live one.
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    ioWr = 1'b1;
    ioAddr = a;
    ioWrData = d;
    @(negedge ref_clk);
    ioWr = 1'b0;
    ioAddr = ~a;
    ioWrData = ~d;
  endtask
  // Read data is taken a full cycle after the strobe edge.
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    ioRd = 1'b1;
    ioAddr = a;
    @(negedge ref_clk);
    ioRd = 1'b0;
    ioAddr = ~a;
    @(negedge ref_clk);
    d = ioRdData;
  endtask
  // Index first, then the data port.
  task automatic cfg(input logic [7:0] i, input logic [7:0] d);
    wr(ipw_pkg::IDX_PORT_ADDR, i);
    wr(ipw_pkg::DAT_PORT_ADDR, d);
  endtask
  task automatic rdReg(input logic [7:0] i, output logic [7:0] d);
    wr(ipw_pkg::IDX_PORT_ADDR, i);
    rd(ipw_pkg::DAT_PORT_ADDR, d);
  endtask
  // Key written twice in a row opens access; one lock key closes it.
  task automatic unlock();
    wr(ipw_pkg::IDX_PORT_ADDR, ipw_pkg::UNLOCK_KEY);
    wr(ipw_pkg::IDX_PORT_ADDR, ipw_pkg::UNLOCK_KEY);
  endtask
  task automatic lock();
    wr(ipw_pkg::IDX_PORT_ADDR, ipw_pkg::LOCK_KEY);
  endtask
endmodule

// ---- verification/ipw_watchdog_asserts.sv ----
/*
  Port checker for the watchdog top, attached by bind.
  Shadows lock, index, bank and enable from the host strobes.
*/
module ipw_watchdog_asserts #(
  parameter int SEC_DIV = 5
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ioWr,
  input wire logic ioRd,
  input wire logic [15:0] ioAddr,
  input wire logic [7:0] ioWrData,
  input wire logic [7:0] ioRdData,
  input wire logic mouseActivity,
  input wire logic kbdActivity,
  input wire logic timeoutResetSelectJumper,
  input wire logic wdtIrq,
  input wire logic sysReset
);
  logic unlockQ, keyQ, bankQ, enQ, idxW, datW, outAny;
  logic [7:0] idxQ;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Data writes count only while unlocked.
  assign idxW = ioWr && ioAddr == ipw_pkg::IDX_PORT_ADDR;
  assign datW = ioWr && ioAddr == ipw_pkg::DAT_PORT_ADDR && unlockQ;
  assign outAny = wdtIrq | sysReset;
  // Shadow state, so each property knows which register a data write hits.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      {unlockQ, keyQ, bankQ, enQ, idxQ} <= '0;
    end else begin
      if (idxW && unlockQ) begin
        idxQ <= ioWrData;
        unlockQ <= ioWrData != ipw_pkg::LOCK_KEY;
        keyQ <= 1'b0;
      end else if (idxW) begin
        keyQ <= ioWrData == ipw_pkg::UNLOCK_KEY;
        unlockQ <= keyQ && ioWrData == ipw_pkg::UNLOCK_KEY;
      end
      if (datW && idxQ == ipw_pkg::BANK_SELECT_IDX)
        bankQ <= ioWrData == ipw_pkg::WDT_BANK_VALUE;
      if (datW && bankQ && idxQ == ipw_pkg::FUNCTION_ACTIVATE_IDX)
        enQ <= ioWrData == ipw_pkg::ENABLE_VALUE;
    end
  end
  a_out_exclusive: assert property (!(wdtIrq && sysReset)) else $error("irq and reset both high");
  a_irq_strap_low: assert property (wdtIrq |-> !timeoutResetSelectJumper) else $error("irq with strap high");
  a_reset_strap_high: assert property (sysReset |-> timeoutResetSelectJumper) else $error("reset with strap low");
  a_rddata_holds: assert property (!($past(ioRd) && $past(unlockQ) && $past(ioAddr) == ipw_pkg::DAT_PORT_ADDR)
    |-> $stable(ioRdData)) else $error("read data moved without read");
  a_locked_write_quiet: assert property (ioWr && ioAddr == ipw_pkg::DAT_PORT_ADDR && !unlockQ && !outAny
    |=> !outAny [*3]) else $error("locked write acted");
  a_force_timeout: assert property (datW && bankQ && enQ && idxQ == ipw_pkg::RESTART_STATUS_IDX && ioWrData[5]
    |-> ##[1:3] outAny) else $error("forced timeout missing");
  a_status_sticky: assert property ($fell(outAny) |-> $past(datW) && $past(ioWrData[4])
    && $past(idxQ) == ipw_pkg::RESTART_STATUS_IDX) else $error("timeout dropped by itself");
  a_reload_quiet: assert property (SEC_DIV >= 3 && datW && bankQ && idxQ == ipw_pkg::TIMEOUT_COUNT_IDX && !outAny
    |=> (!outAny) [*3]) else $error("timeout right after reload");
  c_irq: cover property ($rose(wdtIrq));
  c_reset: cover property ($rose(sysReset));
  c_activity: cover property ((mouseActivity || kbdActivity) && enQ);
endmodule
bind ipw_watchdog ipw_watchdog_asserts #(.SEC_DIV(SEC_DIV)) chk (.ref_clk(ref_clk), .rst_n(rst_n), .ioWr(ioWr),
  .ioRd(ioRd), .ioAddr(ioAddr), .ioWrData(ioWrData), .ioRdData(ioRdData), .mouseActivity(mouseActivity),
  .kbdActivity(kbdActivity), .timeoutResetSelectJumper(timeoutResetSelectJumper), .wdtIrq(wdtIrq),
  .sysReset(sysReset));

// ---- verification/tb_top.sv ----
/*
  Self-checking bench for the watchdog top with a host model.
  Assumes a short second divider so one second takes only five cycles.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SD = 5;
  localparam logic [7:0] F5 = ipw_pkg::COUNT_UNIT_SELECT_IDX;
  localparam logic [7:0] F6 = ipw_pkg::TIMEOUT_COUNT_IDX;
  localparam logic [7:0] F7 = ipw_pkg::RESTART_STATUS_IDX;
  `define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin miscompares++; \
    $display("MISMATCH %s expected %0h seen %0h", n, e, a); end end
  logic ref_clk = 1'b0, rst_n = 1'b0, ioWr, ioRd, mouseAct = 1'b0, kbdAct = 1'b0, jmp = 1'b0, wdtIrq, sysReset;
  logic [15:0] ioAddr, lfsr = 16'hfef2;
  logic [7:0] ioWrData, ioRdData, v;
  int miscompares = 0, compares = 0, n, cnt;
  // Free-running 25 MHz clock.
  always #20 ref_clk = ~ref_clk;
  ipw_watchdog #(.SEC_DIV(SD)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .ioWr(ioWr), .ioRd(ioRd), .ioAddr(ioAddr),
    .ioWrData(ioWrData), .ioRdData(ioRdData), .mouseActivity(mouseAct), .kbdActivity(kbdAct),
    .timeoutResetSelectJumper(jmp), .wdtIrq(wdtIrq), .sysReset(sysReset));
  ipw_host_model host (.ref_clk(ref_clk), .ioWr(ioWr), .ioRd(ioRd), .ioAddr(ioAddr), .ioWrData(ioWrData),
    .ioRdData(ioRdData));
  function automatic logic [15:0] nextL(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic int expCyc(int c, logic mins);
    return c * SD * (mins ? ipw_pkg::SEC_PER_MIN : 1);
  endfunction
  task automatic report_and_stop();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Cycles until a timeout shows; a required one that never comes ends the run.
  task automatic measure(input int lim, output int c, input bit must);
    c = 0;
    while ((wdtIrq | sysReset) !== 1'b1 && c <= lim) begin
      @(negedge ref_clk);
      c++;
    end
    if (must && c > lim) begin
      miscompares++;
      report_and_stop();
    end
  endtask
  // Main sequence: lock, reset values, counting, restarts, force, relock.
  initial begin
    repeat (20) @(negedge ref_clk);
    rst_n = 1'b1;
    `CHK("irq", 1'b0, wdtIrq)
    host.cfg(F7, 8'h20);
    measure(10, cnt, 0);
    `CHK("locked force", 1'b1, cnt > 10)
    host.wr(ipw_pkg::IDX_PORT_ADDR, ipw_pkg::UNLOCK_KEY);
    host.wr(ipw_pkg::IDX_PORT_ADDR, 8'h07);
    host.wr(ipw_pkg::IDX_PORT_ADDR, ipw_pkg::UNLOCK_KEY);
    host.cfg(ipw_pkg::BANK_SELECT_IDX, ipw_pkg::WDT_BANK_VALUE);
    host.unlock();
    host.rdReg(ipw_pkg::BANK_SELECT_IDX, v);
    `CHK("bank", ipw_pkg::BANK_RESET, v)
    host.cfg(ipw_pkg::BANK_SELECT_IDX, ipw_pkg::WDT_BANK_VALUE);
    host.cfg(ipw_pkg::FUNCTION_ACTIVATE_IDX, ipw_pkg::ENABLE_VALUE);
    host.rdReg(F5, v);
    `CHK("unit", ipw_pkg::UNIT_RESET, v)
    host.rdReg(F7, v);
    `CHK("ctrl", ipw_pkg::CTRL_RESET, v)
    host.cfg(F6, 8'h00);
    measure(3 * SD, cnt, 0);
    `CHK("zero count", 1'b1, cnt > 3 * SD)
    for (int i = 0; i < 4; i++) begin
      lfsr = nextL(lfsr);
      n = (i == 0) ? 255 : int'(lfsr[2:0]) + 1;
      host.cfg(F6, n[7:0]);
      measure(expCyc(n, 0) + 2, cnt, 1);
      `CHK("seconds", expCyc(n, 0), cnt)
      host.rdReg(F7, v);
      `CHK("status", 1'b1, v[ipw_pkg::TIMEOUT_STATUS_BIT])
      host.cfg(F7, 8'h10);
      `CHK("cleared", 1'b0, wdtIrq)
    end
    // Minute unit, with a mid-count rewrite restarting the whole count.
    host.cfg(F5, 8'h08);
    host.rdReg(F5, v);
    `CHK("minutes", 1'b1, v[ipw_pkg::UNIT_MINUTES_BIT])
    host.cfg(F6, 8'h01);
    repeat (2 * SD) @(negedge ref_clk);
    host.cfg(F6, 8'h01);
    measure(expCyc(1, 1) + 2, cnt, 1);
    `CHK("minute reload", expCyc(1, 1), cnt)
    host.cfg(F7, 8'h10);
    host.cfg(F5, 8'h00);
    // Activity mid-count pushes the deadline out and restarts the tick phase.
    for (int s = 0; s < 2; s++) begin
      host.cfg(F7, s ? 8'h40 : 8'h80);
      host.cfg(F6, 8'h02);
      repeat (SD) @(negedge ref_clk);
      mouseAct = (s == 0);
      kbdAct = (s == 1);
      @(negedge ref_clk);
      mouseAct = 1'b0;
      kbdAct = 1'b0;
      measure(3 * SD, cnt, 1);
      `CHK("activity restart", 1'b1, cnt >= SD + 1 && cnt <= 2 * SD + 1)
      host.cfg(F7, 8'h10);
    end
    for (int j = 0; j < 2; j++) begin
      jmp = j[0];
      host.cfg(F7, 8'h20);
      repeat (3) @(negedge ref_clk);
      `CHK("force irq", j == 0, wdtIrq)
      `CHK("force reset", j == 1, sysReset)
      host.rdReg(F7, v);
      `CHK("force bit", 1'b0, v[ipw_pkg::FORCE_TIMEOUT_BIT])
      host.cfg(F7, 8'h10);
    end
    jmp = 1'b0;
    // A disabled function must not count, and another bank must not reach the watchdog registers.
    host.cfg(ipw_pkg::FUNCTION_ACTIVATE_IDX, 8'h00);
    host.cfg(F6, 8'h02);
    measure(3 * SD, cnt, 0);
    `CHK("disabled", 1'b1, cnt > 3 * SD)
    host.cfg(ipw_pkg::BANK_SELECT_IDX, 8'h00);
    host.cfg(F7, 8'h20);
    measure(10, cnt, 0);
    `CHK("other bank", 1'b1, cnt > 10)
    // Restore bank and enable with a stopped count, so the relock check can trip.
    host.cfg(ipw_pkg::BANK_SELECT_IDX, ipw_pkg::WDT_BANK_VALUE);
    host.cfg(F6, 8'h00);
    host.cfg(ipw_pkg::FUNCTION_ACTIVATE_IDX, ipw_pkg::ENABLE_VALUE);
    host.wr(ipw_pkg::IDX_PORT_ADDR, F7);
    host.lock();
    host.wr(ipw_pkg::DAT_PORT_ADDR, 8'h20);
    measure(10, cnt, 0);
    `CHK("relocked", 1'b1, cnt > 10)
    report_and_stop();
  end
endmodule
